// ---- cbn_defs.vh ----
// Constants for the branch-on-carry-clear and negate execution block.
// Assumes 16-bit instruction words and a 16-bit register file of eight registers.
`ifndef CBN_DEFS_VH
`define CBN_DEFS_VH
`define CBN_PC_STEP 16'h0002
`define CBN_BRC_OPC 7'h10
`define CBN_BRC_OPC_MSB 15
`define CBN_BRC_OPC_LSB 9
`define CBN_TRI_OPC_MSB 15
`define CBN_TRI_OPC_LSB 11
`define CBN_OFF_MSB 8
`define CBN_OFF_LSB 0
`define CBN_TRI_OPC 5'h03
`define CBN_TRI_SUB 2'h0
`define CBN_RD_MSB 10
`define CBN_RD_LSB 8
`define CBN_RA_MSB 7
`define CBN_RA_LSB 5
`define CBN_RB_MSB 4
`define CBN_RB_LSB 2
`define CBN_FN_MSB 1
`define CBN_FN_LSB 0
`define CBN_ZERO_REG 3'h0
`define CBN_SIGN_BIT 15
`define CBN_FLAG_N 3
`define CBN_FLAG_Z 2
`define CBN_FLAG_V 1
`define CBN_FLAG_C 0
`define CBN_PC_RESET 16'h0000
`define CBN_FLAGS_RESET 4'h0
`define CBN_RESULT_RESET 16'h0000
`define CBN_REG_RESET 16'h0000
`define CBN_REG1_RESET 16'h0001
`define CBN_REG2_RESET 16'h8000
`define CBN_REG3_RESET 16'h7fff
`define CBN_REG4_RESET 16'hffff
`endif

// ---- cbn_regfile.v ----
// Eight-entry 16-bit general-purpose register file with two read ports.
// Assumes a single clock; writes to the zero register are discarded.
`timescale 1ns/1ps
`include "cbn_defs.vh"
module cbn_regfile (
	input wire clk,
	input wire resetn,
	input wire clkEn,
	input wire [2:0] rdAddrA,
	input wire [2:0] rdAddrB,
	output wire [15:0] rdDataA,
	output wire [15:0] rdDataB,
	input wire wrEn,
	input wire [2:0] wrAddr,
	input wire [15:0] wrData
);
	reg [15:0] regs_q [0:7];

	// The zero register always reads zero so subtraction from it negates.
	assign rdDataA = (rdAddrA == `CBN_ZERO_REG) ? 16'h0000 : regs_q[rdAddrA];
	assign rdDataB = (rdAddrB == `CBN_ZERO_REG) ? 16'h0000 : regs_q[rdAddrB];

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// There is no load path, so an all-zero file could only ever yield zero.
			regs_q[0] <= `CBN_REG_RESET;
			regs_q[1] <= `CBN_REG1_RESET;
			regs_q[2] <= `CBN_REG2_RESET;
			regs_q[3] <= `CBN_REG3_RESET;
			regs_q[4] <= `CBN_REG4_RESET;
			regs_q[5] <= `CBN_REG_RESET;
			regs_q[6] <= `CBN_REG_RESET;
			regs_q[7] <= `CBN_REG_RESET;
		end else if (clkEn && wrEn && wrAddr != `CBN_ZERO_REG) begin
			regs_q[wrAddr] <= wrData;
		end
	end
endmodule // cbn_regfile

// ---- cbn_exec.v ----
// Execution slice: conditional branch on carry clear and triadic subtract/negate.
// Assumes fetch memory answers an aligned word read with fetchValid held until accepted.
`timescale 1ns/1ps
`include "cbn_defs.vh"

// Contract
// - Carry clear: PC becomes PC plus 2 plus offset*2.
// - Same as higher-same; two fetches taken, one not.
// - Negate writes zero minus operand into destination.
// - Negative flag equals result bit 15.
// - Zero flag set when result is zero.
// - Overflow is source bit15 AND result bit15.
// - Carry is source bit15 OR result bit15.
// - Negate completes in one program fetch.
// - Fetch is aligned word read, one cycle minimum.
// - Taken branch refetches target; untaken one fetch.
module cbn_exec (
	input wire clk,
	input wire resetn,
	input wire clkEn,
	output wire fetchReq,
	output reg [15:0] fetchAddr,
	input wire fetchValid,
	input wire [15:0] fetchData,
	output wire [15:0] pcOut,
	output wire [3:0] flagsOut,
	output wire [15:0] resultOut,
	output wire retire,
	output wire illegal
);
	// A taken branch spends one extra fetch in the refill state.
	localparam ST_FETCH = 1'b0;
	localparam ST_REFILL = 1'b1;

	reg state_q;
	reg state_d;
	reg [15:0] pc_q;
	reg [15:0] pc_d;
	reg [3:0] flags_q;
	reg [3:0] flags_d;
	reg [15:0] result_q;
	reg [15:0] result_d;
	reg retire_q;
	reg retire_d;
	reg illegal_q;
	reg illegal_d;
	reg wrEn;
	wire [15:0] opA;
	wire [15:0] opB;
	wire [15:0] diff;
	wire isBrc;
	wire isSub;
	wire [8:0] relOff;
	wire [2:0] dstSel;
	wire [2:0] srcASel;
	wire [2:0] srcBSel;
	wire [3:0] subFlags;
	wire [15:0] pcSeq;
	wire [15:0] pcTarget;
	wire carryClear;

	// Word fetches are always aligned, so bit 0 of the address is forced low.
	function [15:0] cbn_align;
		input [15:0] a;
		begin
			cbn_align = {a[15:1], 1'b0};
		end
	endfunction

	// The 9-bit signed offset counts words, so it is sign-extended and doubled.
	function [15:0] cbn_offset9;
		input [8:0] off;
		begin
			cbn_offset9 = {{6{off[8]}}, off, 1'b0};
		end
	endfunction

	// Every instruction is one word, so the sequential successor is two bytes on.
	function [15:0] cbn_next;
		input [15:0] pc;
		begin
			cbn_next = pc + `CBN_PC_STEP;
		end
	endfunction

	// All seven opcode bits are compared; a shorter match would let the other
	// conditional branches alias onto this one.
	function cbn_is_brc;
		input [15:0] w;
		begin
			cbn_is_brc = w[`CBN_BRC_OPC_MSB:`CBN_BRC_OPC_LSB] == `CBN_BRC_OPC;
		end
	endfunction

	function cbn_is_sub;
		input [15:0] w;
		begin
			cbn_is_sub = w[`CBN_TRI_OPC_MSB:`CBN_TRI_OPC_LSB] == `CBN_TRI_OPC
				&& w[`CBN_FN_MSB:`CBN_FN_LSB] == `CBN_TRI_SUB;
		end
	endfunction

	// Flags after a subtract, packed N, Z, V, C from high to low.
	function [3:0] cbn_sub_flags;
		input [15:0] src;
		input [15:0] res;
		begin
			cbn_sub_flags[`CBN_FLAG_N] = res[`CBN_SIGN_BIT];
			cbn_sub_flags[`CBN_FLAG_Z] = res == 16'h0000;
			cbn_sub_flags[`CBN_FLAG_V] = src[`CBN_SIGN_BIT] & res[`CBN_SIGN_BIT];
			cbn_sub_flags[`CBN_FLAG_C] = src[`CBN_SIGN_BIT] | res[`CBN_SIGN_BIT];
		end
	endfunction

	// Field slices are named once so decode and operand selects cannot drift apart.
	assign isBrc = cbn_is_brc(fetchData);
	assign isSub = cbn_is_sub(fetchData);
	assign relOff = fetchData[`CBN_OFF_MSB:`CBN_OFF_LSB];
	assign dstSel = fetchData[`CBN_RD_MSB:`CBN_RD_LSB];
	assign srcASel = fetchData[`CBN_RA_MSB:`CBN_RA_LSB];
	assign srcBSel = fetchData[`CBN_RB_MSB:`CBN_RB_LSB];

	// Operand selects come straight from the fetched word, so reads settle in decode.
	cbn_regfile uRegs (
		.clk(clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.rdAddrA(srcASel),
		.rdAddrB(srcBSel),
		.rdDataA(opA),
		.rdDataB(opB),
		.wrEn(wrEn),
		.wrAddr(dstSel),
		.wrData(diff)
	);

	// Negate is the triadic subtract with the zero register as minuend.
	assign diff = opA - opB;
	assign subFlags = cbn_sub_flags(opB, diff);
	// The target adder runs every cycle; only the carry test decides its use.
	assign carryClear = !flags_q[`CBN_FLAG_C];
	assign pcSeq = cbn_next(pc_q);
	assign pcTarget = pcSeq + cbn_offset9(relOff);

	// A fetch is requested in every cycle out of reset; the refill state discards one word.
	assign fetchReq = resetn;
	assign pcOut = pc_q;
	assign flagsOut = flags_q;
	assign resultOut = result_q;
	assign retire = retire_q;
	assign illegal = illegal_q;

	always @* begin
		fetchAddr = cbn_align(pc_q);
	end

	always @* begin
		state_d = state_q;
		pc_d = pc_q;
		flags_d = flags_q;
		result_d = result_q;
		retire_d = 1'b0;
		illegal_d = 1'b0;
		wrEn = 1'b0;
		case (state_q)
			ST_FETCH: begin
				if (fetchValid) begin
					if (isBrc) begin
						retire_d = 1'b1;
						// Flags are untouched by the branch in both outcomes.
						if (carryClear) begin
							pc_d = pcTarget;
							state_d = ST_REFILL;
						end else begin
							pc_d = pcSeq;
						end
					end else if (isSub) begin
						wrEn = 1'b1;
						retire_d = 1'b1;
						result_d = diff;
						pc_d = pcSeq;
						flags_d = subFlags;
					end else begin
						// Opcodes outside this slice are flagged and skipped.
						illegal_d = 1'b1;
						pc_d = pcSeq;
					end
				end
			end
			ST_REFILL: begin
				// Second fetch of a taken branch refills from the target.
				if (fetchValid) begin
					state_d = ST_FETCH;
				end
			end
			default: begin
				state_d = ST_FETCH;
			end
		endcase
	end

	// Every register holds while clkEn is low, so a stalled word cannot retire twice.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_FETCH;
			pc_q <= `CBN_PC_RESET;
			flags_q <= `CBN_FLAGS_RESET;
			result_q <= `CBN_RESULT_RESET;
			retire_q <= 1'b0;
			illegal_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			pc_q <= pc_d;
			flags_q <= flags_d;
			result_q <= result_d;
			retire_q <= retire_d;
			illegal_q <= illegal_d;
		end
	end
endmodule // cbn_exec

// ---- cbn_exec_props.sv ----
// Checker for the branch and negate execution slice.
// Assumes it is bound to cbn_exec and sees only its ports.
`timescale 1ns/1ps
module cbn_exec_props (
	input wire clk,
	input wire resetn,
	input wire clkEn,
	input wire fetchValid,
	input wire [15:0] fetchData,
	input wire [15:0] fetchAddr,
	input wire [15:0] pcOut,
	input wire [3:0] flagsOut,
	input wire [15:0] resultOut,
	input wire retire
);
	logic skip_q;
	wire go = clkEn && fetchValid && !skip_q;
	wire isBrc = fetchData[15:9] == 7'h10;
	wire isSub = fetchData[15:11] == 5'h03 && fetchData[1:0] == 2'h0;
	wire [15:0] tgt = pcOut + 16'h0002 + {{6{fetchData[8]}}, fetchData[8:0], 1'b0};
	// The word after a taken branch is a refill slot and must not execute.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) skip_q <= 1'b0;
		else if (clkEn && fetchValid) skip_q <= go && isBrc && !flagsOut[0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence takenBr; go && isBrc && !flagsOut[0]; endsequence
	sequence subOp; go && isSub; endsequence
	sequence negOp; go && isSub && fetchData[7:5] == 3'h0; endsequence
	a_branch_target: assert property (takenBr |=> pcOut == $past(tgt) && $stable(flagsOut))
		else $error("branch target wrong");
	a_branch_untaken: assert property (go && isBrc && flagsOut[0] |=> pcOut == $past(pcOut) + 16'h0002)
		else $error("untaken branch wrong");
	a_refill_slot: assert property (skip_q && clkEn && fetchValid |=> !retire && $stable(pcOut))
		else $error("refill slot executed");
	a_sub_step: assert property (subOp |=> retire && pcOut == $past(pcOut) + 16'h0002)
		else $error("negate step wrong");
	a_neg_sign: assert property (subOp |=> flagsOut[3] == resultOut[15])
		else $error("negative flag wrong");
	a_neg_zero: assert property (subOp |=> flagsOut[2] == (resultOut == 16'h0000))
		else $error("zero flag wrong");
	a_over_carry: assert property (subOp |=> (!flagsOut[1] || flagsOut[3]) && (!flagsOut[3] || flagsOut[0]))
		else $error("overflow or carry wrong");
	// Negating x sets bit 15 of x or of -x unless x is zero; both only for 8000.
	a_neg_carry: assert property (negOp |=> flagsOut[0] == (resultOut != 16'h0000))
		else $error("negate carry wrong");
	a_neg_overflow: assert property (negOp |=> flagsOut[1] == (resultOut == 16'h8000))
		else $error("negate overflow wrong");
	a_fetch_word: assert property (fetchAddr[0] == 1'b0 && fetchAddr == pcOut)
		else $error("fetch address wrong");
endmodule // cbn_exec_props
bind cbn_exec cbn_exec_props u_props (
	.clk(clk),
	.resetn(resetn),
	.clkEn(clkEn),
	.fetchValid(fetchValid),
	.fetchData(fetchData),
	.fetchAddr(fetchAddr),
	.pcOut(pcOut),
	.flagsOut(flagsOut),
	.resultOut(resultOut),
	.retire(retire)
);

// ---- cbn_exec_tb.sv ----
// Testbench for the branch and negate execution slice.
// Assumes results show one edge after each accepted fetch word.
`timescale 1ns/1ps
module cbn_exec_tb;
	reg clk = 0, resetn = 0, clkEn = 1, fetchValid = 0;
	reg [15:0] fetchData = 16'h0000;
	wire fetchReq, retire, illegal;
	wire [15:0] fetchAddr, pcOut, resultOut;
	wire [3:0] flagsOut;
	int err_count = 0, n_tests = 0;
	cbn_exec u_dut (
		.clk(clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.fetchReq(fetchReq),
		.fetchAddr(fetchAddr),
		.fetchValid(fetchValid),
		.fetchData(fetchData),
		.pcOut(pcOut),
		.flagsOut(flagsOut),
		.resultOut(resultOut),
		.retire(retire),
		.illegal(illegal)
	);
	initial forever #2.5 clk = ~clk;
	task chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task run(input [15:0] w);
		@(negedge clk);
		fetchValid = 1;
		fetchData = w;
		@(negedge clk);
		fetchValid = 0;
	endtask
	// Negate of the zero register from the reset state.
	task t_negate;
		run(16'h1d00);
		chk("pc", 16'h0002, pcOut);
		chk("result", 16'h0000, resultOut);
		chk("flags", 16'h0004, {12'h000, flagsOut});
		chk("retire", 16'h0001, {15'h0000, retire});
		chk("illegal", 16'h0000, {15'h0000, illegal});
		chk("fetch req", 16'h0001, {15'h0000, fetchReq});
		chk("fetch addr", 16'h0002, fetchAddr);
	endtask
	// Outputs while reset is held, then release on a falling edge.
	task t_reset_hold;
		@(negedge clk);
		chk("req in reset", 16'h0000, {15'h0000, fetchReq});
		chk("pc in reset", 16'h0000, pcOut);
		resetn = 1;
	endtask
	// Negate from a known source word, checking result, all flags and the step.
	task t_neg(input [15:0] w, input [15:0] res, input [3:0] fl, input [15:0] pc);
		run(w);
		chk("neg result", res, resultOut);
		chk("neg flags", {12'h000, fl}, {12'h000, flagsOut});
		chk("neg pc", pc, pcOut);
		chk("neg retire", 16'h0001, {15'h0000, retire});
	endtask
	// With carry set the branch falls through and the very next word executes.
	task t_untaken;
		run({7'h10, 9'h005});
		chk("untaken pc", 16'h000c, pcOut);
		chk("untaken flags", 16'h000b, {12'h000, flagsOut});
		chk("untaken retire", 16'h0001, {15'h0000, retire});
		t_neg(16'h1f10, 16'h0001, 4'h1, 16'h000e);
	endtask
	// A write aimed at the zero register is dropped, so it still negates to zero.
	task t_zero_reg;
		t_neg(16'h1808, 16'h8000, 4'hb, 16'h0016);
		run(16'h1d00);
		chk("zero reg", 16'h0000, resultOut);
	endtask
	// A neighbouring branch code and a subtract with a nonzero function field
	// lie outside this slice and must be skipped without retiring.
	task t_illegal;
		run(16'h2200);
		chk("alias illegal", 16'h0001, {15'h0000, illegal});
		chk("alias retire", 16'h0000, {15'h0000, retire});
		chk("alias pc", 16'h001a, pcOut);
		run(16'h1d01);
		chk("fn illegal", 16'h0001, {15'h0000, illegal});
		chk("fn flags", 16'h0004, {12'h000, flagsOut});
	endtask
	// With the clock enable low an offered word is not taken and nothing moves.
	task t_freeze;
		clkEn = 0;
		run(16'h1d08);
		chk("frozen pc", 16'h001c, pcOut);
		chk("frozen flags", 16'h0004, {12'h000, flagsOut});
		chk("frozen fetch", 16'h001c, fetchAddr);
		clkEn = 1;
	endtask
	// Reset in mid-run clears the fetch pointer and reseeds the register file.
	task t_mid_reset;
		resetn = 0;
		@(negedge clk);
		chk("req in reset", 16'h0000, {15'h0000, fetchReq});
		chk("addr in reset", 16'h0000, fetchAddr);
		resetn = 1;
		t_neg(16'h1e18, 16'h0000, 4'h4, 16'h0002);
	endtask
	// Taken branch at an offset limit, then the discarded refill word.
	task t_branch(input [8:0] off, input [15:0] tgt);
		run({7'h10, off});
		chk("target", tgt, pcOut);
		chk("flags", 16'h0004, {12'h000, flagsOut});
		run(16'h1d00);
		chk("slot retire", 16'h0000, {15'h0000, retire});
		chk("slot pc", tgt, pcOut);
		run(16'h1d00);
		chk("after", tgt + 16'h0002, pcOut);
	endtask
	task stop_test;
		$display("mismatches %0d comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		t_reset_hold;
		t_negate;
		t_branch(9'h0ff, 16'h0202);
		t_branch(9'h100, 16'h0006);
		t_neg(16'h1d08, 16'h8000, 4'hb, 16'h000a);
		t_untaken;
		t_neg(16'h1e04, 16'hffff, 4'h9, 16'h0010);
		t_neg(16'h1e18, 16'h0001, 4'h1, 16'h0012);
		t_neg(16'h1c0c, 16'h8001, 4'h9, 16'h0014);
		t_zero_reg;
		t_illegal;
		t_freeze;
		t_mid_reset;
		stop_test;
	end
	// The tests need about 50 cycles; this waits 1000.
	initial begin
		#5000;
		err_count++;
		stop_test;
	end
endmodule // cbn_exec_tb
